// File: core/mau_unit.sv
// Behaviour
// - extension bit 5 enables address masking
// - indirect: address ANDed with extended mask
// - postinc: raw address, masked plus-four update
// - predec: masked minus-four for both
// - displacement: masked sum with extended displacement
// - signed and unsigned multiply to register
// - multiply add/subtract into chosen accumulator
// - accumulate while core loads memory operand
// - load accumulator, store accumulator to register
// - copy full 48-bit accumulator
// - status register write, read, to flags
// - load 16-bit extension halves of each pair
// - read extension pairs, mask write/read
// - first stage overlaps address-generate stage
// - one accumulator op per cycle, no stall
// - store after update held three cycles
// - hold only while that accumulator busy
// - two bits choose one of three formats
// - fractional minimum is minus one
// - mask keeps 16 bits, reads upper ones
// - fractional mode ignores scale factor
`timescale 1ns/1ps
`default_nettype none
module mau_unit import mau_pkg::*; (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // instruction from core pipeline
    input wire mau_req_t i_req,
    // answers to core pipeline
    output mau_resp_t o_resp,
    output logic [MAU_NUM_ACC-1:0] o_acc_busy
);

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic is_mac(input mau_op_t op);
        is_mac = (op == OP_MAC) || (op == OP_MULTIPLY_SUBTRACT_OP) || (op == OP_MAC_LD) || (op == OP_MULTIPLY_SUBTRACT_OP_LD);
    endfunction

    function automatic logic is_sub(input mau_op_t op);
        is_sub = (op == OP_MULTIPLY_SUBTRACT_OP) || (op == OP_MULTIPLY_SUBTRACT_OP_LD);
    endfunction

    // accumulators an instruction will overwrite
    function automatic logic [3:0] wr_mask(input logic v, input mau_op_t op, input logic [1:0] a,
                                           input logic hi);
        wr_mask = 4'h0;
        if (v && (is_mac(op) || op == OP_LD_ACC || op == OP_CP_ACC)) begin
            wr_mask[a] = 1'b1;
        end else if (v && op == OP_LD_EXT) begin
            wr_mask = hi ? 4'hc : 4'h3;
        end
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [47:0] accs [MAU_NUM_ACC];
    logic [7:0] sr;
    logic [15:0] mask;
    mau_stage_t p1;
    mau_stage_t p2;
    mau_stage_t p3;

    // ----------------------------------------
    // address-generate/execute stage
    // ----------------------------------------
    // format chosen from the status bits
    wire logic su = sr[MAU_SR_SU];
    wire logic fi = sr[MAU_SR_FI];
    wire mau_fmt_t fmt = fi ? FMT_SFRAC : (su ? FMT_UINT : FMT_SINT);

    // store of busy accumulator or pair is refused
    wire logic st_acc_hold = (i_req.op == OP_ST_ACC) && o_acc_busy[i_req.acc_x];
    wire logic st_ext_hold = (i_req.op == OP_ST_EXT) &&
        (i_req.ext_hi ? |o_acc_busy[3:2] : |o_acc_busy[1:0]);
    wire logic accepted = i_req.valid && !st_acc_hold && !st_ext_hold;
    wire logic is_ld = (i_req.op == OP_MAC_LD) || (i_req.op == OP_MULTIPLY_SUBTRACT_OP_LD);

    // operand address with optional masking
    wire logic mask_on = is_ld && i_req.ext_word[MAU_EXT_MASK_BIT];
    wire logic [31:0] mask_full = {MAU_MASK_UPPER, mask};
    wire logic [31:0] sign_extended_displacement = {{16{i_req.disp[15]}}, i_req.disp};
    wire logic [31:0] an_inc = i_req.an + MAU_ADDR_STEP;
    wire logic [31:0] an_dec = i_req.an - MAU_ADDR_STEP;
    wire logic [31:0] an_disp = i_req.an + sign_extended_displacement;
    wire logic [31:0] raw_addr = (i_req.ea == EA_PREDEC) ? an_dec :
                                 (i_req.ea == EA_DISP) ? an_disp : i_req.an;
    // postinc keeps the raw register, others are masked
    wire logic [31:0] operand_address = (mask_on && i_req.ea != EA_POSTINC) ?
                                        (raw_addr & mask_full) : raw_addr;
    wire logic [31:0] an_step = (i_req.ea == EA_POSTINC) ? an_inc : an_dec;
    wire logic [31:0] an_next = mask_on ? (an_step & mask_full) : an_step;
    wire logic an_upd = i_req.ea == EA_POSTINC || i_req.ea == EA_PREDEC;

    // operand forming for accumulate
    wire logic [15:0] y16 = i_req.upper_y ? i_req.src_y[31:16] : i_req.src_y[15:0];
    wire logic [15:0] x16 = i_req.upper_x ? i_req.src_x[31:16] : i_req.src_x[15:0];
    wire logic ey = (fmt == FMT_SINT) && y16[15];
    wire logic ex = (fmt == FMT_SINT) && x16[15];
    wire logic [31:0] opy_w = (fmt == FMT_SFRAC) ? {y16, 16'h0000} : {{16{ey}}, y16};
    wire logic [31:0] opx_w = (fmt == FMT_SFRAC) ? {x16, 16'h0000} : {{16{ex}}, x16};
    wire logic [31:0] opy = i_req.word ? opy_w : i_req.src_y;
    wire logic [31:0] opx = i_req.word ? opx_w : i_req.src_x;

    // plain multiply, integer regardless of mode
    wire logic mul_s = (i_req.op == OP_SIGNED_MULTIPLY_OP);
    wire logic [31:0] my = i_req.word ? {{16{mul_s & i_req.src_y[15]}}, i_req.src_y[15:0]} : i_req.src_y;
    wire logic [31:0] mx = i_req.word ? {{16{mul_s & i_req.src_x[15]}}, i_req.src_x[15:0]} : i_req.src_x;
    wire logic [65:0] mul_full = $signed({mul_s & my[31], my}) * $signed({mul_s & mx[31], mx});
    wire logic [31:0] mul_res = mul_full[31:0];

    // answer data for reads
    wire logic [31:0] ext01 = {accs[1][47:32], accs[0][47:32]};
    wire logic [31:0] ext23 = {accs[3][47:32], accs[2][47:32]};
    wire logic [31:0] rd_data =
        (i_req.op == OP_SIGNED_MULTIPLY_OP || i_req.op == OP_UNSIGNED_MULTIPLY_OP) ? mul_res :
        (i_req.op == OP_ST_ACC) ? accs[i_req.acc_x][31:0] :
        (i_req.op == OP_ST_SR || i_req.op == OP_SR_CCR) ? {24'h00_0000, sr} :
        (i_req.op == OP_ST_MASK) ? {MAU_MASK_UPPER, mask} :
        (i_req.op == OP_ST_EXT) ? (i_req.ext_hi ? ext23 : ext01) : 32'h0000_0000;
    wire logic answers = i_req.op == OP_SIGNED_MULTIPLY_OP || i_req.op == OP_UNSIGNED_MULTIPLY_OP || i_req.op == OP_ST_ACC ||
        i_req.op == OP_ST_SR || i_req.op == OP_SR_CCR || i_req.op == OP_ST_MASK || i_req.op == OP_ST_EXT;

    // stage entry, captured straight from the request cycle
    mau_stage_t next_p1;
    assign next_p1.valid = accepted && (is_mac(i_req.op) || i_req.op == OP_LD_ACC ||
                           i_req.op == OP_CP_ACC || i_req.op == OP_LD_EXT);
    assign next_p1.op = i_req.op;
    assign next_p1.acc = i_req.acc_x;
    assign next_p1.src = i_req.acc_y;
    assign next_p1.ext_hi = i_req.ext_hi;
    assign next_p1.sf = i_req.sf;
    assign next_p1.fmt = fmt;
    assign next_p1.opy = opy;
    assign next_p1.opx = opx;
    assign next_p1.data = i_req.src_y;
    assign next_p1.p48 = 48'h0000_0000_0000;

    // ----------------------------------------
    // product stage
    // ----------------------------------------
    wire logic sgn = p1.fmt != FMT_UINT;
    wire logic [65:0] prod66 = $signed({sgn & p1.opy[31], p1.opy}) * $signed({sgn & p1.opx[31], p1.opx});
    wire logic [63:0] prod = prod66[63:0];
    // fractional: doubled product, minus one squared zero-filled
    wire logic [63:0] pf = {prod[62:0], 1'b0};
    wire logic neg1 = (p1.opy == MAU_FRAC_MIN) && (p1.opx == MAU_FRAC_MIN);
    wire logic [47:0] frac48 = {neg1 ? 8'h00 : {8{pf[63]}}, pf[63:24]};
    // integer: optional one-bit scale
    wire logic [39:0] p40 = prod[39:0];
    wire logic rfill = (p1.fmt == FMT_UINT) ? 1'b0 : p40[39];
    wire logic [39:0] p40s = (p1.sf == MAU_SF_LEFT) ? {p40[38:0], 1'b0} :
                             (p1.sf == MAU_SF_RIGHT) ? {rfill, p40[39:1]} : p40;
    wire logic [47:0] int48 = {{8{p40s[39]}}, p40s};

    mau_stage_t next_p2;
    always_comb begin
        next_p2 = p1;
        next_p2.p48 = (p1.fmt == FMT_SFRAC) ? frac48 : int48;
    end

    // ----------------------------------------
    // accumulate stage, writes at its end
    // ----------------------------------------
    wire logic [47:0] acc_cur = accs[p3.acc];
    wire logic [47:0] acc_sum = is_sub(p3.op) ? (acc_cur - p3.p48) : (acc_cur + p3.p48);
    wire logic [47:0] acc_new = is_mac(p3.op) ? acc_sum :
        (p3.op == OP_CP_ACC) ? accs[p3.src] :
        {{16{p3.data[31]}}, p3.data};
    wire logic [3:0] p3_wr = wr_mask(p3.valid, p3.op, p3.acc, p3.ext_hi);
    wire logic ext_ld = p3.valid && (p3.op == OP_LD_EXT);

    // busy map for the next cycle: ops in the three later stages
    wire logic [3:0] next_busy = wr_mask(next_p1.valid, i_req.op, i_req.acc_x, i_req.ext_hi) |
        wr_mask(p1.valid, p1.op, p1.acc, p1.ext_hi) |
        wr_mask(p2.valid, p2.op, p2.acc, p2.ext_hi);

    // answer to the core
    mau_resp_t next_resp;
    assign next_resp.valid = accepted && answers;
    assign next_resp.data = rd_data;
    assign next_resp.to_ccr = accepted && (i_req.op == OP_SR_CCR);
    assign next_resp.addr_valid = accepted && is_ld;
    assign next_resp.addr = operand_address;
    assign next_resp.an_we = accepted && is_ld && an_upd;
    assign next_resp.an = an_next;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // pipeline stages
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            p1 <= '0;
            p2 <= '0;
            p3 <= '0;
        end else begin
            p1 <= next_p1;
            p2 <= next_p2;
            p3 <= p2;
        end
    end

    // status and mask registers
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sr <= MAU_SR_RESET;
            mask <= MAU_MASK_RESET;
        end else begin
            if (accepted && i_req.op == OP_LD_SR) begin
                sr <= i_req.src_y[7:0];
            end
            if (accepted && i_req.op == OP_LD_MASK) begin
                mask <= i_req.src_y[15:0];
            end
        end
    end

    // accumulators with extension halves
    for (genvar g = 0; g < MAU_NUM_ACC; g++) begin : g_acc
        localparam logic [1:0] IDX = 2'(g);
        wire logic [15:0] ext_half = IDX[0] ? p3.data[31:16] : p3.data[15:0];
        always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
            if (!i_rst_n) begin
                accs[g] <= 48'h0000_0000_0000;
            end else if (ext_ld && p3_wr[g]) begin
                accs[g] <= {ext_half, accs[g][31:0]};
            end else if (p3_wr[g]) begin
                accs[g] <= acc_new;
            end
        end
    end

    // outputs
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_resp <= '0;
            o_acc_busy <= 4'h0;
        end else begin
            o_resp <= next_resp;
            o_acc_busy <= next_busy;
        end
    end

endmodule // mau_unit
`default_nettype wire

// File: inc/mau_pkg.sv
`default_nettype none
package mau_pkg;

    // ----------------------------------------
    // instruction codes and modes
    // ----------------------------------------
    typedef enum logic [4:0] {
        OP_NOP     = 5'h00,
        OP_SIGNED_MULTIPLY_OP    = 5'h01,
        OP_UNSIGNED_MULTIPLY_OP    = 5'h02,
        OP_MAC     = 5'h03,
        OP_MULTIPLY_SUBTRACT_OP    = 5'h04,
        OP_MAC_LD  = 5'h05,
        OP_MULTIPLY_SUBTRACT_OP_LD = 5'h06,
        OP_LD_ACC  = 5'h07,
        OP_ST_ACC  = 5'h08,
        OP_CP_ACC  = 5'h09,
        OP_LD_SR   = 5'h0a,
        OP_ST_SR   = 5'h0b,
        OP_SR_CCR  = 5'h0c,
        OP_LD_MASK = 5'h0d,
        OP_ST_MASK = 5'h0e,
        OP_LD_EXT  = 5'h0f,
        OP_ST_EXT  = 5'h10
    } mau_op_t;

    typedef enum logic [1:0] {
        EA_IND     = 2'b00,
        EA_POSTINC = 2'b01,
        EA_PREDEC  = 2'b10,
        EA_DISP    = 2'b11
    } mau_ea_t;

    typedef enum logic [1:0] {
        FMT_SINT  = 2'b00,
        FMT_UINT  = 2'b01,
        FMT_SFRAC = 2'b10
    } mau_fmt_t;

    // ----------------------------------------
    // constants
    // ----------------------------------------
    localparam int MAU_NUM_ACC = 4;
    localparam int MAU_PIPE_DEPTH = 4;
    localparam int MAU_STORE_STALL = MAU_PIPE_DEPTH - 1;
    localparam int MAU_EXT_MASK_BIT = 5;
    localparam int MAU_SR_SU = 6;
    localparam int MAU_SR_FI = 5;
    localparam int MAU_SR_RT = 4;
    localparam logic [7:0] MAU_SR_RESET = 8'h00;
    localparam logic [15:0] MAU_MASK_RESET = 16'hffff;
    localparam logic [15:0] MAU_MASK_UPPER = 16'hffff;
    localparam logic [31:0] MAU_ADDR_STEP = 32'h0000_0004;
    localparam logic [31:0] MAU_FRAC_MIN = 32'h8000_0000;
    localparam logic [1:0] MAU_SF_LEFT = 2'h1;
    localparam logic [1:0] MAU_SF_RIGHT = 2'h3;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        mau_op_t op;
        logic [1:0] acc_x;
        logic [1:0] acc_y;
        logic ext_hi;
        logic word;
        logic upper_y;
        logic upper_x;
        logic [1:0] sf;
        logic [31:0] src_y;
        logic [31:0] src_x;
        logic [15:0] ext_word;
        mau_ea_t ea;
        logic [31:0] an;
        logic [15:0] disp;
    } mau_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
        logic to_ccr;
        logic addr_valid;
        logic [31:0] addr;
        logic an_we;
        logic [31:0] an;
    } mau_resp_t;

    typedef struct packed {
        logic valid;
        mau_op_t op;
        logic [1:0] acc;
        logic [1:0] src;
        logic ext_hi;
        logic [1:0] sf;
        mau_fmt_t fmt;
        logic [31:0] opy;
        logic [31:0] opx;
        logic [31:0] data;
        logic [47:0] p48;
    } mau_stage_t;

endpackage
`default_nettype wire

// File: testbench/mau_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module mau_core_model import mau_pkg::*; (
    // instruction from bench, busy map from unit
    input wire mau_req_t i_ins,
    input wire logic [MAU_NUM_ACC-1:0] i_acc_busy,
    // request to unit, hold to bench
    output mau_req_t o_req,
    output logic o_hold
);
    // stores wait while the accumulator or pair is pending
    wire logic st_acc = i_ins.op == OP_ST_ACC && i_acc_busy[i_ins.acc_x];
    wire logic [1:0] pair = i_ins.ext_hi ? i_acc_busy[3:2] : i_acc_busy[1:0];
    wire logic st_ext = i_ins.op == OP_ST_EXT && |pair;
    assign o_hold = i_ins.valid && (st_acc || st_ext);
    assign o_req = i_ins;
endmodule // mau_core_model
`default_nettype wire

// File: testbench/mau_unit_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module mau_unit_mon import mau_pkg::*; (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // watched ports
    input wire mau_req_t i_req,
    input wire mau_resp_t o_resp,
    input wire logic [MAU_NUM_ACC-1:0] o_acc_busy
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic [15:0] mk;
    // request kinds and expected addresses
    wire logic v = i_req.valid;
    wire logic ld = v && i_req.op inside {OP_MAC_LD, OP_MULTIPLY_SUBTRACT_OP_LD};
    wire logic mac = v && i_req.op inside {OP_MAC, OP_MULTIPLY_SUBTRACT_OP, OP_MAC_LD, OP_MULTIPLY_SUBTRACT_OP_LD};
    wire logic wr = mac || (v && i_req.op inside {OP_LD_ACC, OP_CP_ACC, OP_LD_EXT});
    wire logic st = v && i_req.op == OP_ST_ACC;
    wire logic sb = o_acc_busy[i_req.acc_x];
    wire logic [1:0] ax = i_req.acc_x;
    wire logic [31:0] m = i_req.ext_word[MAU_EXT_MASK_BIT] ? {MAU_MASK_UPPER, mk} : 32'hffff_ffff;
    wire logic [31:0] dec = i_req.an - MAU_ADDR_STEP;
    wire logic [31:0] dsp = i_req.an + {{16{i_req.disp[15]}}, i_req.disp};
    wire logic [31:0] ea_b = i_req.ea == EA_PREDEC ? dec : (i_req.ea == EA_DISP ? dsp : i_req.an);
    wire logic [31:0] ea_a = i_req.ea == EA_POSTINC ? i_req.an : ea_b & m;
    wire logic [31:0] ea_n = (i_req.ea == EA_POSTINC ? i_req.an + MAU_ADDR_STEP : dec) & m;
    // shadow of the mask register
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mk <= MAU_MASK_RESET;
        end else if (v && i_req.op == OP_LD_MASK) begin
            mk <= i_req.src_y[15:0];
        end
    end
    property p_ld_addr; ld |=> o_resp.addr_valid && o_resp.addr == $past(ea_a); endproperty
    a_ld_addr: assert property (p_ld_addr) else $error("operand address wrong");
    property p_ld_an; ld && i_req.ea inside {EA_POSTINC, EA_PREDEC} |=> o_resp.an_we && o_resp.an == $past(ea_n);
    endproperty
    a_ld_an: assert property (p_ld_an) else $error("address register update wrong");
    property p_ld_keep; ld && i_req.ea inside {EA_IND, EA_DISP} |=> !o_resp.an_we; endproperty
    a_ld_keep: assert property (p_ld_keep) else $error("address register updated");
    property p_mask_rd; v && i_req.op == OP_ST_MASK |=> o_resp.valid && o_resp.data == {MAU_MASK_UPPER, $past(mk)};
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("mask read wrong");
    property p_busy_on; mac |=> o_acc_busy[$past(ax)]; endproperty
    a_busy_on: assert property (p_busy_on) else $error("accumulator not marked pending");
    property p_busy_off; !wr [*3] |=> o_acc_busy == '0; endproperty
    a_busy_off: assert property (p_busy_off) else $error("pending longer than three cycles");
    property p_st_hold; st && sb |=> !o_resp.valid; endproperty
    a_st_hold: assert property (p_st_hold) else $error("store answered while pending");
    property p_st_go; st && !sb |=> o_resp.valid && !o_resp.to_ccr; endproperty
    a_st_go: assert property (p_st_go) else $error("store not answered");
    property p_ccr; v && i_req.op == OP_SR_CCR |=> o_resp.valid && o_resp.to_ccr; endproperty
    a_ccr: assert property (p_ccr) else $error("flag transfer missing");
    c_hold: cover property (st && sb);
    c_mask: cover property (ld && i_req.ext_word[MAU_EXT_MASK_BIT]);
    c_back: cover property (mac ##1 st);
endmodule // mau_unit_mon
bind mau_unit mau_unit_mon u_mon (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(i_req), .o_resp(o_resp),
    .o_acc_busy(o_acc_busy));
`default_nettype wire

// File: testbench/mau_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mau_unit_tb import mau_pkg::*;;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    mau_req_t ins = '0;
    mau_req_t req;
    mau_req_t q;
    mau_resp_t resp;
    mau_resp_t got;
    logic [3:0] busy;
    logic hold;
    int failures = 0;
    int n_tests = 0;
    int cyc = 0;
    int st;
    logic [31:0] ea_e [5] = '{32'h0001_0ff0, 32'h0001_0ff8, 32'h0001_0ff0, 32'h0001_0000, 32'h0001_0ff8};
    logic [31:0] an_e [5] = '{32'h0000_0000, 32'h0001_0ff0, 32'h0001_0ff0, 32'h0000_0000, 32'h0001_0ffc};
    always #12.5 i_clk_sys = ~i_clk_sys;
    mau_core_model u_core (.i_ins(ins), .i_acc_busy(busy), .o_req(req), .o_hold(hold));
    mau_unit uut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req), .o_resp(resp), .o_acc_busy(busy));
    // keep the last answer
    always @(negedge i_clk_sys) if (resp.valid || resp.addr_valid) got = resp;
    // hang guard
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            failures++;
            test_done();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    function automatic mau_req_t rq(mau_op_t op, logic [1:0] ax, logic [31:0] y, logic [31:0] x);
        rq = '0;
        rq.valid = 1'b1;
        rq.op = op;
        rq.acc_x = ax;
        rq.src_y = y;
        rq.src_x = x;
    endfunction
    // present one instruction, count held cycles, return on the take edge
    task automatic go(input mau_req_t r);
        got = '0;
        ins <= r;
        st = 0;
        @(negedge i_clk_sys);
        while (hold && st < 10) begin
            st++;
            @(negedge i_clk_sys);
        end
        @(posedge i_clk_sys);
    endtask
    task automatic gap(input int n);
        ins <= '0;
        repeat (n) @(posedge i_clk_sys);
    endtask
    task automatic t_ld_st;
        go(rq(OP_LD_ACC, 2'h2, 32'h8000_0001, 32'h0000_0000));
        gap(4);
        go(rq(OP_ST_ACC, 2'h2, 32'h0000_0000, 32'h0000_0000));
        gap(1);
        chk("acc2", 32'h8000_0001, got.data);
        $display("test load store done");
    endtask
    task automatic t_mac;
        go(rq(OP_LD_ACC, 2'h0, 32'h0000_0000, 32'h0000_0000));
        gap(4);
        go(rq(OP_MAC, 2'h0, 32'h0000_0003, 32'h0000_0005));
        go(rq(OP_ST_ACC, 2'h0, 32'h0000_0000, 32'h0000_0000));
        chk("stall", 32'(MAU_STORE_STALL), 32'(st));
        gap(1);
        chk("acc0", 32'h0000_000f, got.data);
        $display("test mac stall done");
    endtask
    task automatic t_multiply_subtract_op;
        q = rq(OP_MULTIPLY_SUBTRACT_OP, 2'h1, 32'h0000_0002, 32'h0000_0007);
        q.sf = MAU_SF_LEFT;
        go(q);
        go(rq(OP_LD_ACC, 2'h3, 32'h0000_1234, 32'h0000_0000));
        go(rq(OP_LD_MASK, 2'h0, 32'h1234_0ff0, 32'h0000_0000));
        go(rq(OP_ST_ACC, 2'h1, 32'h0000_0000, 32'h0000_0000));
        chk("stall", 32'h0000_0001, 32'(st));
        gap(1);
        chk("acc1", 32'hffff_ffe4, got.data);
        $display("test interleave done");
    endtask
    task automatic t_mul;
        q = rq(OP_SIGNED_MULTIPLY_OP, 2'h0, 32'h0000_ffff, 32'h0000_0003);
        q.word = 1'b1;
        go(q);
        gap(1);
        chk("signed_multiply_op", 32'hffff_fffd, got.data);
        q.op = OP_UNSIGNED_MULTIPLY_OP;
        go(q);
        gap(1);
        chk("unsigned_multiply_op", 32'h0002_fffd, got.data);
        $display("test multiply done");
    endtask
    task automatic t_mask;
        go(rq(OP_ST_MASK, 2'h0, 32'h0000_0000, 32'h0000_0000));
        gap(1);
        chk("mask", 32'hffff_0ff0, got.data);
        for (int i = 0; i < 5; i++) begin
            q = rq(OP_MAC_LD, 2'h3, 32'h0000_0000, 32'h0000_0000);
            q.ea = (i < 4) ? mau_ea_t'(i[1:0]) : EA_POSTINC;
            q.ext_word = (i < 4) ? 16'h0020 : 16'h0000;
            q.an = 32'h0001_0ff8;
            q.disp = 16'h0010;
            go(q);
            gap(1);
            chk("addr", ea_e[i], got.addr);
            if (i == 1 || i == 2 || i == 4) chk("an", an_e[i], got.an);
        end
        $display("test masking done");
    endtask
    task automatic t_ext;
        go(rq(OP_LD_EXT, 2'h0, 32'h00ab_00cd, 32'h0000_0000));
        gap(4);
        go(rq(OP_ST_EXT, 2'h0, 32'h0000_0000, 32'h0000_0000));
        gap(1);
        chk("ext01", 32'h00ab_00cd, got.data);
        q = rq(OP_CP_ACC, 2'h3, 32'h0000_0000, 32'h0000_0000);
        go(q);
        gap(4);
        q = rq(OP_ST_EXT, 2'h0, 32'h0000_0000, 32'h0000_0000);
        q.ext_hi = 1'b1;
        go(q);
        gap(1);
        chk("ext23", 32'h00cd_ffff, got.data);
        go(rq(OP_ST_ACC, 2'h3, 32'h0000_0000, 32'h0000_0000));
        gap(1);
        chk("acc3", 32'h0000_000f, got.data);
        $display("test extension done");
    endtask
    task automatic t_sr;
        go(rq(OP_LD_SR, 2'h0, 32'h0000_0050, 32'h0000_0000));
        go(rq(OP_ST_SR, 2'h0, 32'h0000_0000, 32'h0000_0000));
        gap(1);
        chk("status", 32'h0000_0050, got.data);
        go(rq(OP_SR_CCR, 2'h0, 32'h0000_0000, 32'h0000_0000));
        gap(1);
        chk("to_ccr", 32'h0000_0001, {31'h0000_0000, got.to_ccr});
        // fractional minus one squared, scale factor ignored
        go(rq(OP_LD_SR, 2'h0, 32'h0000_0020, 32'h0000_0000));
        go(rq(OP_LD_ACC, 2'h2, 32'h0000_0000, 32'h0000_0000));
        q = rq(OP_MAC, 2'h2, 32'h0000_8000, 32'h0000_8000);
        q.word = 1'b1;
        q.sf = MAU_SF_LEFT;
        go(q);
        q = rq(OP_ST_EXT, 2'h0, 32'h0000_0000, 32'h0000_0000);
        q.ext_hi = 1'b1;
        go(q);
        gap(1);
        chk("frac", 32'h00cd_0080, got.data);
        $display("test status done");
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (10) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        @(posedge i_clk_sys);
        t_ld_st();
        t_mac();
        t_multiply_subtract_op();
        t_mul();
        t_mask();
        t_ext();
        t_sr();
        test_done();
    end
endmodule // mau_unit_tb
`default_nettype wire
